// *** logic/ssp_decoder.sv ***
// Decoder for a second-stage entry mapping a 2-MByte page.
// Assumes entries and context come from page-walk logic on clk_i.
//
// Summary of operation
// - Page base comes from entry bits host_addr_width-1 down to 21.
// - Bit 11 is the snoop_required_bit for the mapped page.
// - Without snoop_control_support bit 11 is reserved and must be zero.
// - Dirty flag in bit 9 marks a successful write-seeking translation.
// - Accessed bit 8 and dirty bit 9 are ignored unless access_dirty_enable.
// - Bit 7 one means a 2-MByte leaf, zero means a next-level table.
// - Without 2-MB large page support bit 7 is reserved and must be zero.
// - Bits 6 and 5:3 are ignored if override is off or mode is legacy.
// - The attribute-table ignore applies only to nested coherent requests.
// - Flag zero uses the attr_table_setting, flag one excludes it.
// - With override on, bits 5:3 give the type for 010b/011b coherent.
// - Type codes 0,1,4,5,6 are UC,WC,WT,WP,WB; others are reserved.
// - With execute_check_enable set, bit 2 zero denies execute.
// - Bit 1 zero denies write.
// - Bit 0 zero denies read.
// - With zero-length read support, writable pages pass zero-length reads.
//
// The implementer's own choices: register access over Wishbone and the placing of the registers.
`default_nettype none

module ssp_decoder
    import ssp_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    // Entry and context from the walker
    input  wire logic        entry_valid_i,
    input  wire logic [63:0] entry_i,
    input  wire logic        access_dirty_enable_i,
    input  wire logic        execute_check_enable_i,
    input  wire logic        memory_type_override_enable_i,
    input  wire logic [1:0]  table_mode_select_i,
    input  wire logic [2:0]  translation_type_select_i,
    input  wire logic        coherent_i,
    input  wire logic        zero_len_i,
    // Decode result
    output logic             result_valid_o,
    output logic             fault_o,
    output logic             leaf_o,
    output logic [51:0]      page_base_o,
    output logic             snoop_o,
    output logic             accessed_o,
    output logic             dirty_o,
    output logic             use_attr_table_o,
    output logic             mem_type_valid_o,
    output logic [2:0]       mem_type_o,
    output logic             grant_read_o,
    output logic             grant_write_o,
    output logic             grant_exec_o
);

    default clocking chk_cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // Capability register
    logic        sc_q,  sc_d;
    logic        lp_q,  lp_d;
    logic        zlr_q, zlr_d;
    logic [5:0]  haw_q, haw_d;
    logic        ack_q, ack_d;
    logic [31:0] rdat_q, rdat_d;
    logic [31:0] cnt_q, cnt_d;

    logic        wb_req;
    assign wb_req = wb_cyc_i && wb_stb_i && !ack_q;

    always_comb begin
        sc_d   = sc_q;
        lp_d   = lp_q;
        zlr_d  = zlr_q;
        haw_d  = haw_q;
        ack_d  = wb_req;
        rdat_d = 32'h0000_0000;
        if (wb_req && wb_we_i && wb_adr_i == REG_CAP) begin
            if (wb_sel_i[0]) begin
                sc_d  = wb_dat_i[CAP_SC_BIT];
                lp_d  = wb_dat_i[CAP_LP_BIT];
                zlr_d = wb_dat_i[CAP_ZLR_BIT];
            end
            if (wb_sel_i[1]) begin
                haw_d = wb_dat_i[CAP_HAW_HI:CAP_HAW_LO];
            end
        end
        if (wb_req && !wb_we_i) begin
            case (wb_adr_i)
                REG_CAP: begin
                    rdat_d[CAP_SC_BIT]            = sc_q;
                    rdat_d[CAP_LP_BIT]            = lp_q;
                    rdat_d[CAP_ZLR_BIT]           = zlr_q;
                    rdat_d[CAP_HAW_HI:CAP_HAW_LO] = haw_q;
                end
                REG_STATUS: begin
                    rdat_d[ST_FAULT_BIT] = fault_o;
                    rdat_d[ST_LEAF_BIT]  = leaf_o;
                    rdat_d[ST_MTV_BIT]   = mem_type_valid_o;
                end
                REG_COUNT: rdat_d = cnt_q;
                default:   rdat_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sc_q   <= CAP_SC_RST;
            lp_q   <= CAP_LP_RST;
            zlr_q  <= CAP_ZLR_RST;
            haw_q  <= CAP_HAW_RST;
            ack_q  <= 1'b0;
            rdat_q <= 32'h0000_0000;
        end else begin
            sc_q   <= sc_d;
            lp_q   <= lp_d;
            zlr_q  <= zlr_d;
            haw_q  <= haw_d;
            ack_q  <= ack_d;
            rdat_q <= rdat_d;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;

    // Entry decode, combinational
    logic [51:0] addr_mask;
    logic        rsv_err, leaf, mt_legal, mt_apply, ign_apply;
    logic        mode_on;
    logic [2:0]  mt_code;

    assign mt_code = entry_i[MT_HI:MT_LO];

    ssp_mt_dec u_mt_dec (
        .code_i  (mt_code),
        .legal_o (mt_legal)
    );

    always_comb begin
        // bits at or above host_addr_width are not address
        for (int i = 0; i < 52; i++) begin
            addr_mask[i] = (i >= ADDR_LOW) && (7'(i) < {1'b0, haw_q});
        end
        // reserved bits above the address width and 20:12
        rsv_err = |(entry_i[ADDR_TOP:ADDR_LOW] & ~addr_mask[51:21])
                  || |entry_i[RSV_MID_HI:RSV_MID_LO]
                  || entry_i[RSV_HI_BIT];
        // snoop bit reserved without snoop control
        if (!sc_q && entry_i[SNOOP_BIT]) begin
            rsv_err = 1'b1;
        end
        // large page flag reserved without 2-MB support
        if (!lp_q && entry_i[LARGE_BIT]) begin
            rsv_err = 1'b1;
        end
        // leaf only when the large page flag is set
        leaf = entry_i[LARGE_BIT];
        // override off or legacy mode hides bits 6:3
        mode_on = memory_type_override_enable_i
                  && table_mode_select_i != MODE_LEGACY;
        // type applies to 010b or 011b from coherent devices
        mt_apply = mode_on && coherent_i
                   && (translation_type_select_i == XLAT_SS_ONLY
                       || translation_type_select_i == XLAT_NESTED);
        // ignore flag only for nested coherent requests
        ign_apply = mode_on && coherent_i
                    && translation_type_select_i == XLAT_NESTED;
        // a reserved type code in use is a bad entry
        if (leaf && mt_apply && !mt_legal) begin
            rsv_err = 1'b1;
        end
    end

    // Registered result
    logic        val_q,  val_d;
    logic        flt_q,  flt_d;
    logic        leaf_q, leaf_d;
    logic [51:0] base_q, base_d;
    logic        snp_q,  snp_d;
    logic        acc_q,  acc_d;
    logic        dty_q,  dty_d;
    logic        uat_q,  uat_d;
    logic        mtv_q,  mtv_d;
    logic [2:0]  mt_q,   mt_d;
    logic        gr_q,   gr_d;
    logic        gw_q,   gw_d;
    logic        gx_q,   gx_d;

    always_comb begin
        val_d  = entry_valid_i;
        flt_d  = flt_q;
        leaf_d = leaf_q;
        base_d = base_q;
        snp_d  = snp_q;
        acc_d  = acc_q;
        dty_d  = dty_q;
        uat_d  = uat_q;
        mtv_d  = mtv_q;
        mt_d   = mt_q;
        gr_d   = gr_q;
        gw_d   = gw_q;
        gx_d   = gx_q;
        cnt_d  = cnt_q;
        if (entry_valid_i) begin
            cnt_d  = cnt_q + 32'h0000_0001;
            flt_d  = rsv_err;
            leaf_d = leaf && !rsv_err;
            // page base, low 21 bits zero
            base_d = entry_i[51:0] & addr_mask;
            // snoop attribute, only with snoop control
            snp_d  = sc_q && entry_i[SNOOP_BIT];
            acc_d  = access_dirty_enable_i && entry_i[ACCESSED_BIT];
            // dirty means a write was translated
            dty_d  = access_dirty_enable_i && entry_i[DIRTY_BIT];
            // flag one drops the attribute table setting
            uat_d  = !(ign_apply && entry_i[IGN_ATTR_BIT]);
            mtv_d  = mt_apply && mt_legal;
            mt_d   = mt_apply ? mt_code : MT_UC;
            gr_d   = entry_i[READ_BIT]
                     || (zlr_q && zero_len_i && entry_i[WRITE_BIT]);
            gw_d   = entry_i[WRITE_BIT];
            gx_d   = !execute_check_enable_i || entry_i[EXEC_BIT];
            // a faulted or non-leaf entry grants nothing
            if (rsv_err || !leaf) begin
                gr_d  = 1'b0;
                gw_d  = 1'b0;
                gx_d  = 1'b0;
                mtv_d = 1'b0;
                snp_d = 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            val_q  <= 1'b0;
            flt_q  <= 1'b0;
            leaf_q <= 1'b0;
            base_q <= 52'h0_0000_0000_0000;
            snp_q  <= 1'b0;
            acc_q  <= 1'b0;
            dty_q  <= 1'b0;
            uat_q  <= 1'b1;
            mtv_q  <= 1'b0;
            mt_q   <= MT_UC;
            gr_q   <= 1'b0;
            gw_q   <= 1'b0;
            gx_q   <= 1'b0;
            cnt_q  <= 32'h0000_0000;
        end else begin
            val_q  <= val_d;
            flt_q  <= flt_d;
            leaf_q <= leaf_d;
            base_q <= base_d;
            snp_q  <= snp_d;
            acc_q  <= acc_d;
            dty_q  <= dty_d;
            uat_q  <= uat_d;
            mtv_q  <= mtv_d;
            mt_q   <= mt_d;
            gr_q   <= gr_d;
            gw_q   <= gw_d;
            gx_q   <= gx_d;
            cnt_q  <= cnt_d;
        end
    end

    assign result_valid_o   = val_q;
    assign fault_o          = flt_q;
    assign leaf_o           = leaf_q;
    assign page_base_o      = base_q;
    assign snoop_o          = snp_q;
    assign accessed_o       = acc_q;
    assign dirty_o          = dty_q;
    assign use_attr_table_o = uat_q;
    assign mem_type_valid_o = mtv_q;
    assign mem_type_o       = mt_q;
    assign grant_read_o     = gr_q;
    assign grant_write_o    = gw_q;
    assign grant_exec_o     = gx_q;

    chk_base_low_zero: assert property (result_valid_o
        |-> page_base_o[20:0] == 21'h00_0000)
        else $error("page base low bits not zero");
    chk_snoop_sc: assert property (entry_valid_i && !sc_q
        && entry_i[SNOOP_BIT] |=> fault_o && !snoop_o)
        else $error("snoop bit without support not faulted");
    chk_ad_gate: assert property (entry_valid_i
        && !access_dirty_enable_i |=> !accessed_o && !dirty_o)
        else $error("accessed or dirty shown while disabled");
    chk_dirty_flag: assert property (entry_valid_i
        && access_dirty_enable_i |=> dirty_o == $past(entry_i[DIRTY_BIT]))
        else $error("dirty flag not reported");
    chk_nonleaf_none: assert property (entry_valid_i
        && !entry_i[LARGE_BIT] |=> !leaf_o && !grant_read_o && !grant_write_o)
        else $error("non-leaf entry granted access");
    chk_lp_support: assert property (entry_valid_i && !lp_q
        && entry_i[LARGE_BIT] |=> fault_o)
        else $error("large page without support not faulted");
    chk_legacy_mt: assert property (entry_valid_i && table_mode_select_i
        == MODE_LEGACY |=> !mem_type_valid_o && use_attr_table_o)
        else $error("type bits used in legacy mode");
    chk_ign_nested: assert property (entry_valid_i
        && translation_type_select_i != XLAT_NESTED |=> use_attr_table_o)
        else $error("attribute table skipped outside nested");
    chk_exec_deny: assert property (entry_valid_i
        && execute_check_enable_i && !entry_i[EXEC_BIT] |=> !grant_exec_o)
        else $error("execute granted with exec permit clear");
    chk_write_deny: assert property (entry_valid_i
        && !entry_i[WRITE_BIT] |=> !grant_write_o)
        else $error("write granted with write permit clear");
    chk_read_deny: assert property (entry_valid_i && !entry_i[READ_BIT]
        && !(zlr_q && zero_len_i && entry_i[WRITE_BIT]) |=> !grant_read_o)
        else $error("read granted with read permit clear");
    chk_rsv_fault: assert property (entry_valid_i
        && |entry_i[RSV_MID_HI:RSV_MID_LO] |=> fault_o && !leaf_o)
        else $error("reserved bits not faulted");
    chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");

endmodule : ssp_decoder

`default_nettype wire

// *** logic/ssp_mt_dec.sv ***
// Memory type code decoder for the 2-MByte page entry.
// Assumes the code is already qualified by the caller's context.
`default_nettype none

module ssp_mt_dec
    import ssp_pkg::*;
(
    input  wire logic [2:0] code_i,
    output logic            legal_o
);

    always_comb begin
        case (code_i)
            MT_UC, MT_WC, MT_WT, MT_WP, MT_WB: legal_o = 1'b1;
            default:                           legal_o = 1'b0;
        endcase
    end

endmodule : ssp_mt_dec

`default_nettype wire

// *** logic/ssp_pkg.sv ***
// Constants for the 2-MByte second-stage page entry decoder.
// Assumes a 20 MHz unit clock and a classic Wishbone register port.
`default_nettype none

package ssp_pkg;

    // Entry field positions
    localparam int unsigned ENT_W         = 64;
    localparam int unsigned ADDR_TOP      = 51;
    localparam int unsigned ADDR_LOW      = 21;
    localparam int unsigned RSV_MID_HI    = 20;
    localparam int unsigned RSV_MID_LO    = 12;
    localparam int unsigned RSV_HI_BIT    = 62;
    localparam int unsigned SNOOP_BIT     = 11;
    localparam int unsigned DIRTY_BIT     = 9;
    localparam int unsigned ACCESSED_BIT  = 8;
    localparam int unsigned LARGE_BIT     = 7;
    localparam int unsigned IGN_ATTR_BIT  = 6;
    localparam int unsigned MT_HI         = 5;
    localparam int unsigned MT_LO         = 3;
    localparam int unsigned EXEC_BIT      = 2;
    localparam int unsigned WRITE_BIT     = 1;
    localparam int unsigned READ_BIT      = 0;

    // Context encodings
    localparam logic [1:0] MODE_LEGACY    = 2'h0;
    localparam logic [2:0] XLAT_SS_ONLY   = 3'h2;
    localparam logic [2:0] XLAT_NESTED    = 3'h3;

    // Memory type codes
    localparam logic [2:0] MT_UC          = 3'h0;
    localparam logic [2:0] MT_WC          = 3'h1;
    localparam logic [2:0] MT_WT          = 3'h4;
    localparam logic [2:0] MT_WP          = 3'h5;
    localparam logic [2:0] MT_WB          = 3'h6;

    // Register map, byte addresses
    localparam logic [3:0] REG_CAP        = 4'h0;
    localparam logic [3:0] REG_STATUS     = 4'h4;
    localparam logic [3:0] REG_COUNT      = 4'h8;

    // Capability register fields and reset values
    localparam int unsigned CAP_SC_BIT    = 0;
    localparam int unsigned CAP_LP_BIT    = 1;
    localparam int unsigned CAP_ZLR_BIT   = 2;
    localparam int unsigned CAP_HAW_LO    = 8;
    localparam int unsigned CAP_HAW_HI    = 13;
    localparam logic        CAP_SC_RST    = 1'b1;
    localparam logic        CAP_LP_RST    = 1'b1;
    localparam logic        CAP_ZLR_RST   = 1'b0;
    localparam logic [5:0]  CAP_HAW_RST   = 6'h30;

    // Status register fields
    localparam int unsigned ST_FAULT_BIT  = 0;
    localparam int unsigned ST_LEAF_BIT   = 1;
    localparam int unsigned ST_MTV_BIT    = 2;

    // Result latency after entry_valid_i, in cycles
    localparam int unsigned RESULT_LAT    = 1;

endpackage : ssp_pkg

`default_nettype wire

// *** sim/ssp_walk_model.sv ***
// Page-walk model: fetches one entry and hands it to the decoder.
// Assumes a one-cycle fetch_i pulse per entry, on the decoder clock.
`default_nettype none

module ssp_walk_model (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        fetch_i,
    input  wire logic        slow_i,
    input  wire logic [63:0] mem_entry_i,
    output logic             entry_valid_o,
    output logic [63:0]      entry_o
);
    timeunit 1ns;
    timeprecision 1ns;

    logic        pend_q;
    logic        pend_d;
    logic        valid_d;
    logic [1:0]  wait_q;
    logic [1:0]  wait_d;
    logic [63:0] hold_q;
    logic [63:0] hold_d;
    logic [63:0] ent_d;

    always_comb begin
        pend_d  = pend_q;
        wait_d  = wait_q;
        hold_d  = hold_q;
        valid_d = 1'h0;
        // Idle lines toggle so a stale entry never looks settled
        ent_d   = ~entry_o;
        if (fetch_i) begin
            pend_d = 1'h1;
            wait_d = slow_i ? 2'h3 : 2'h0;
            hold_d = mem_entry_i;
        end else if (pend_q && wait_q != 2'h0) begin
            wait_d = wait_q - 2'h1;
        end else if (pend_q) begin
            pend_d  = 1'h0;
            valid_d = 1'h1;
            ent_d   = hold_q;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pend_q        <= 1'h0;
            wait_q        <= 2'h0;
            hold_q        <= 64'h0;
            entry_valid_o <= 1'h0;
            entry_o       <= 64'hA5A5_5A5A_A5A5_5A5A;
        end else begin
            pend_q        <= pend_d;
            wait_q        <= wait_d;
            hold_q        <= hold_d;
            entry_valid_o <= valid_d;
            entry_o       <= ent_d;
        end
    end
endmodule : ssp_walk_model

`default_nettype wire

// *** sim/tb.sv ***
// Self-checking bench for the 2-MByte page entry decoder.
// Assumes the walk model supplies entries; context is driven here.
`default_nettype none

module tb
    import ssp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    // Context: ade, ece, override, mode[1:0], type[2:0], coherent, zero_len
    localparam logic [9:0] CX_MT  = 10'h0AE;
    localparam logic [9:0] CX_SS  = 10'h0AA;
    localparam logic [9:0] CX_NC  = 10'h0AC;
    localparam logic [9:0] CX_OFF = 10'h02E;
    localparam logic [9:0] CX_LEG = 10'h08E;

    logic clk_i = 1'h0, rst_i = 1'h1, cyc = 1'h0, stb = 1'h0, we = 1'h0;
    logic fetch = 1'h0, slow = 1'h0, ev, wb_ack, rv, flt, leaf, snoop_required_bit, acc;
    logic dty, uat, mtv, gr, gw, gx;
    logic [3:0]  adr = 4'h0, sel = 4'h0;
    logic [31:0] wdat = 32'h0, wb_rd, rd;
    logic [63:0] fent = 64'h0, entry;
    logic [9:0]  ctx = 10'h0;
    logic [51:0] base;
    logic [2:0]  mt;
    int errors = 0, compares = 0, cycles = 0, ndec = 0;

    always #25 clk_i = ~clk_i;

    ssp_walk_model walker (.clk_i(clk_i), .rst_i(rst_i), .fetch_i(fetch),
        .slow_i(slow), .mem_entry_i(fent), .entry_valid_o(ev),
        .entry_o(entry));

    ssp_decoder dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(wb_rd), .wb_ack_o(wb_ack),
        .entry_valid_i(ev), .entry_i(entry),
        .access_dirty_enable_i(ctx[9]), .execute_check_enable_i(ctx[8]),
        .memory_type_override_enable_i(ctx[7]),
        .table_mode_select_i(ctx[6:5]), .translation_type_select_i(ctx[4:2]),
        .coherent_i(ctx[1]), .zero_len_i(ctx[0]), .result_valid_o(rv),
        .fault_o(flt), .leaf_o(leaf), .page_base_o(base), .snoop_o(snoop_required_bit),
        .accessed_o(acc), .dirty_o(dty), .use_attr_table_o(uat),
        .mem_type_valid_o(mtv), .mem_type_o(mt), .grant_read_o(gr),
        .grant_write_o(gw), .grant_exec_o(gx));

    task automatic give_verdict();
        if (errors == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : give_verdict

    task automatic chk(input string what, input logic [63:0] exp, got);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wb(input logic w, input logic [3:0] a, s,
                      input logic [31:0] d);
        @(posedge clk_i);
        cyc  <= 1'h1;
        stb  <= 1'h1;
        we   <= w;
        adr  <= a;
        sel  <= s;
        wdat <= d;
        // Only the global cycle ceiling ends this wait
        do begin
            @(posedge clk_i);
        end while (wb_ack !== 1'h1);
        rd = wb_rd;
        cyc <= 1'h0;
        stb <= 1'h0;
    endtask : wb

    task automatic dec(input logic [63:0] e, input logic [9:0] c);
        int n;
        n = 0;
        @(posedge clk_i);
        fetch <= 1'h1;
        fent  <= e;
        ctx   <= c;
        @(posedge clk_i);
        fetch <= 1'h0;
        do begin
            @(posedge clk_i);
            n++;
        end while (rv !== 1'h1 && n < 16);
        if (rv !== 1'h1) errors++;
        ndec++;
    endtask : dec

    task automatic t_leaf();
        dec(64'h0000_1234_5660_0087, 10'h000);
        chk("leaf", 1'h1, leaf);
        chk("fault", 1'h0, flt);
        chk("base", 52'h0_1234_5660_0000, base);
        chk("read", 1'h1, gr);
        chk("write", 1'h1, gw);
        dec(64'h0000_0000_0020_0083, 10'h000);
        chk("exec unchecked", 1'h1, gx);
        dec(64'h0000_0000_0020_0083, 10'h100);
        chk("exec checked", 1'h0, gx);
        dec(64'h0000_0000_0020_0085, 10'h000);
        chk("write denied", 1'h0, gw);
        chk("read kept", 1'h1, gr);
        dec(64'h0000_0000_0020_0086, 10'h000);
        chk("read denied", 1'h0, gr);
        dec(64'h0000_0000_0020_0007, 10'h000);
        chk("table pointer", 1'h0, leaf);
        chk("table grant", 1'h0, gr);
        dec(64'h0000_0000_0020_1087, 10'h000);
        chk("rsv mid", 1'h1, flt);
        chk("rsv grant", 1'h0, gr);
        dec(64'h0001_0000_0020_0087, 10'h000);
        chk("rsv addr", 1'h1, flt);
        dec(64'h4000_0000_0020_0087, 10'h000);
        chk("rsv top", 1'h1, flt);
        dec(64'h8010_0000_0020_0087, 10'h000);
        chk("ignored bits", 1'h0, flt);
        chk("ignored base", 52'h0_0000_0020_0000, base);
    endtask : t_leaf

    task automatic t_ad();
        slow <= 1'h1;
        dec(64'h0000_0000_0020_0387, 10'h000);
        chk("acc off", 1'h0, acc);
        chk("dirty off", 1'h0, dty);
        slow <= 1'h0;
        dec(64'h0000_0000_0020_0287, 10'h200);
        chk("acc clear", 1'h0, acc);
        chk("dirty on", 1'h1, dty);
        dec(64'h0000_0000_0020_0187, 10'h200);
        chk("acc on", 1'h1, acc);
        chk("dirty clear", 1'h0, dty);
    endtask : t_ad

    task automatic t_mt();
        logic [2:0] k;
        logic       ok;
        logic [9:0] cx [4] = '{CX_OFF, CX_LEG, CX_NC, CX_SS};
        for (int i = 0; i < 8; i++) begin
            k  = 3'(i);
            ok = k == MT_UC || k == MT_WC || k == MT_WT || k == MT_WP ||
                 k == MT_WB;
            dec(64'h0000_0000_0020_0087 | (64'(k) << 3), CX_MT);
            chk("type valid", ok, mtv);
            chk("type fault", !ok, flt);
            if (ok) chk("type code", k, mt);
        end
        for (int j = 0; j < 4; j++) begin
            dec(64'h0000_0000_0020_00F7, cx[j]);
            chk("type applies", j == 3, mtv);
            chk("attr kept", 1'h1, uat);
        end
        chk("type code ss", MT_WB, mt);
        dec(64'h0000_0000_0020_00F7, CX_MT);
        chk("attr ignored", 1'h0, uat);
        dec(64'h0000_0000_0020_00B7, CX_MT);
        chk("attr used", 1'h1, uat);
    endtask : t_mt

    task automatic t_caps();
        wb(1'h0, REG_CAP, 4'hF, 32'h0);
        chk("cap reset", 32'h0000_3003, rd);
        wb(1'h0, 4'hC, 4'hF, 32'h0);
        chk("unmapped", 32'h0, rd);
        dec(64'h0000_0000_0020_0086, 10'h001);
        chk("zlr off", 1'h0, gr);
        wb(1'h1, REG_CAP, 4'h1, 32'h0000_0007);
        dec(64'h0000_0000_0020_0086, 10'h001);
        chk("zlr on", 1'h1, gr);
        dec(64'h0000_0000_0020_0084, 10'h001);
        chk("zlr no write", 1'h0, gr);
        dec(64'h0000_0000_0020_0887, 10'h000);
        chk("snoop", 1'h1, snoop_required_bit);
        chk("snoop ok", 1'h0, flt);
        wb(1'h1, REG_CAP, 4'h1, 32'h0000_0006);
        dec(64'h0000_0000_0020_0887, 10'h000);
        chk("snoop rsv", 1'h1, flt);
        wb(1'h1, REG_CAP, 4'h1, 32'h0000_0005);
        dec(64'h0000_0000_0020_0087, 10'h000);
        chk("large rsv", 1'h1, flt);
        wb(1'h0, REG_STATUS, 4'hF, 32'h0);
        chk("status fault", 1'h1, rd[0]);
        dec(64'h0000_0000_0020_0007, 10'h000);
        chk("table no lp", 1'h0, flt);
        wb(1'h1, REG_CAP, 4'h3, 32'h0000_2703);
        wb(1'h0, REG_CAP, 4'hF, 32'h0);
        chk("cap write", 32'h0000_2703, rd);
        dec(64'h0000_0080_0020_0087, 10'h000);
        chk("haw rsv", 1'h1, flt);
        dec(64'h0000_0040_0020_0087, 10'h000);
        chk("haw base", 52'h0_0040_0020_0000, base);
        wb(1'h1, REG_COUNT, 4'hF, 32'h0);
        wb(1'h0, REG_COUNT, 4'hF, 32'h0);
        chk("count", 32'(ndec), rd);
    endtask : t_caps

    // Whole run needs well under a thousand cycles
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            errors++;
            give_verdict();
        end
    end

    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'h0;
        @(posedge clk_i);
        chk("reset leaf", 1'h0, leaf);
        chk("reset attr", 1'h1, uat);
        t_leaf();
        t_ad();
        t_mt();
        t_caps();
        give_verdict();
    end
endmodule : tb

`default_nettype wire
